/* File: hw/rtcis_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - ack only a matching address, else release
// - own address is 1010001
// - address byte carries direction in bit 0
// - master opens with start then address
// - pointer advances after every data byte
// - write: address, pointer, data bytes, stop
// - pointed read uses repeated start, no stop
// - read: slave sends pointer register, then next
// - master nacks last byte; slave then releases
// - unpointed read starts after last accessed
// - pointer wraps from 0xF to 0x0
// - long transaction times out to standby
// - receiver acks in ninth clock
module rtcis_dev #(
  parameter int TMO_CYC = rtcis_pkg::TMO_CYCLES
) (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_n_in,
  // serial bus
  rtcis_if.slave                           bus,
  // register read port
  output logic [rtcis_pkg::PTR_W-1:0]      rd_idx_out,
  input  wire logic [rtcis_pkg::BYTE_W-1:0] rd_data_in,
  // register write strobe
  output logic                             wr_en_out,
  output logic [rtcis_pkg::PTR_W-1:0]      wr_idx_out,
  output logic [rtcis_pkg::BYTE_W-1:0]     wr_data_out,
  // status
  output logic                             busy_out
);
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK, S_RDATA, S_RACK, S_HOLD
  } rtcis_dst_t;

  typedef struct packed {
    logic                        scl_s1;
    logic                        scl_s2;
    logic                        scl_p;
    logic                        sda_s1;
    logic                        sda_s2;
    logic                        sda_p;
    rtcis_dst_t                  st;
    rtcis_dst_t                  ack_nxt;
    logic [3:0]                  bit_cnt;
    logic [rtcis_pkg::BYTE_W-1:0] shift;
    logic [rtcis_pkg::PTR_W-1:0] ptr;
    logic                        rw;
    logic                        sda_oe_n;
    logic                        tmo_run;
    logic [31:0]                 tmo;
    logic                        wr_en;
    logic [rtcis_pkg::PTR_W-1:0] wr_idx;
    logic [rtcis_pkg::BYTE_W-1:0] wr_data;
  } rtcis_dev_st_t;

  rtcis_dev_st_t q;
  rtcis_dev_st_t d;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;

  function automatic logic [rtcis_pkg::PTR_W-1:0] ptr_inc(
    input logic [rtcis_pkg::PTR_W-1:0] p
  );
    ptr_inc = rtcis_pkg::PTR_W'(p + rtcis_pkg::PTR_ONE);
  endfunction : ptr_inc

  // ----------------------------------------------------------------
  // line events from synchronised levels
  // ----------------------------------------------------------------
  assign scl_rise  = q.scl_s2 & ~q.scl_p;
  assign scl_fall  = ~q.scl_s2 & q.scl_p;
  assign bus_start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign bus_stop  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    d.scl_s1 = bus.scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p  = q.scl_s2;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.sda_p  = q.sda_s2;
    d.wr_en  = 1'b0;
    if (q.tmo_run)
    begin
      d.tmo = 32'(q.tmo + 32'h0000_0001);
    end
    if (bus_start)
    begin
      // fresh or repeated start: re-arm address match
      d.st       = S_ADDR;
      d.bit_cnt  = '0;
      d.sda_oe_n = 1'b1;
      if (!q.tmo_run)
      begin
        d.tmo     = '0;
        d.tmo_run = 1'b1;
      end
    end
    else if (bus_stop)
    begin
      d.st       = S_IDLE;
      d.sda_oe_n = 1'b1;
      d.tmo_run  = 1'b0;
    end
    else if (q.tmo_run && q.tmo >= 32'(TMO_CYC - 1))
    begin
      // standby until next start; released line reads as ones
      d.st       = S_IDLE;
      d.sda_oe_n = 1'b1;
      d.tmo_run  = 1'b0;
    end
    else
    begin
      unique case (q.st)
        S_IDLE, S_HOLD:
        begin
        end
        S_ADDR, S_PTR, S_WDATA:
        begin
          if (scl_rise)
          begin
            d.shift   = {q.shift[rtcis_pkg::BYTE_W-2:0], q.sda_s2};
            d.bit_cnt = 4'(q.bit_cnt + rtcis_pkg::FIRST_BIT);
          end
          else if (scl_fall && q.bit_cnt == rtcis_pkg::BYTE_BITS)
          begin
            d.bit_cnt  = '0;
            d.st       = S_ACK;
            d.sda_oe_n = rtcis_pkg::ACK_LVL;
            if (q.st == S_ADDR)
            begin
              if (q.shift[rtcis_pkg::BYTE_W-1:1] == rtcis_pkg::OWN_ADDR)
              begin
                d.rw      = q.shift[0];
                d.ack_nxt = (q.shift[0] == rtcis_pkg::DIR_RD) ? S_RDATA : S_PTR;
              end
              else
              begin
                d.st       = S_IDLE;
                d.sda_oe_n = 1'b1;
              end
            end
            else if (q.st == S_PTR)
            begin
              d.ptr     = q.shift[rtcis_pkg::PTR_W-1:0];
              d.ack_nxt = S_WDATA;
            end
            else
            begin
              d.wr_en   = 1'b1;
              d.wr_idx  = q.ptr;
              d.wr_data = q.shift;
              d.ptr     = ptr_inc(q.ptr);
              d.ack_nxt = S_WDATA;
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            d.st       = q.ack_nxt;
            d.sda_oe_n = 1'b1;
            if (q.ack_nxt == S_RDATA)
            begin
              // first byte from current pointer: set or last+1
              d.shift    = rd_data_in;
              d.sda_oe_n = rd_data_in[rtcis_pkg::BYTE_W-1];
              d.bit_cnt  = rtcis_pkg::FIRST_BIT;
            end
          end
        end
        S_RDATA:
        begin
          if (scl_fall)
          begin
            if (q.bit_cnt == rtcis_pkg::BYTE_BITS)
            begin
              d.sda_oe_n = 1'b1;
              d.st       = S_RACK;
              d.bit_cnt  = '0;
              d.ptr      = ptr_inc(q.ptr);
            end
            else
            begin
              d.shift    = {q.shift[rtcis_pkg::BYTE_W-2:0], 1'b0};
              d.sda_oe_n = q.shift[rtcis_pkg::BYTE_W-2];
              d.bit_cnt  = 4'(q.bit_cnt + rtcis_pkg::FIRST_BIT);
            end
          end
        end
        S_RACK:
        begin
          if (scl_rise && q.sda_s2 == rtcis_pkg::NACK_LVL)
          begin
            d.st = S_HOLD;
          end
          else if (scl_fall)
          begin
            d.st       = S_RDATA;
            d.shift    = rd_data_in;
            d.sda_oe_n = rd_data_in[rtcis_pkg::BYTE_W-1];
            d.bit_cnt  = rtcis_pkg::FIRST_BIT;
          end
        end
        default:
        begin
          d.st       = S_IDLE;
          d.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      q          <= '0;
      q.scl_s1   <= 1'b1;
      q.scl_s2   <= 1'b1;
      q.scl_p    <= 1'b1;
      q.sda_s1   <= 1'b1;
      q.sda_s2   <= 1'b1;
      q.sda_p    <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.sda_s_out  = 1'b0;
  assign bus.sda_s_oe_n = q.sda_oe_n;
  assign rd_idx_out     = q.ptr;
  assign wr_en_out      = q.wr_en;
  assign wr_idx_out     = q.wr_idx;
  assign wr_data_out    = q.wr_data;
  assign busy_out       = q.tmo_run;
endmodule : rtcis_dev
`default_nettype wire

/* File: hw/rtcis_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcis_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = rtcis_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } rtcis_fifo_st_t;
  rtcis_fifo_st_t q;
  rtcis_fifo_st_t d;
  logic           push;
  logic           pop;

  assign in_ready_out  = (q.cnt != (AW + 1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = q.mem[q.rd];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = in_data_in;
      d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
    end
    if (pop)
    begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
    end
    d.cnt = (AW + 1)'(q.cnt + (AW + 1)'(push) - (AW + 1)'(pop));
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule : rtcis_fifo

module rtcis_host #(
  parameter int QTR = rtcis_pkg::QTR_CYCLES
) (
  // clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_n_in,
  // serial bus
  rtcis_if.master                           bus,
  // transfer command
  input  wire logic                         cmd_valid_in,
  output logic                              cmd_ready_out,
  input  wire logic                         cmd_read_in,
  input  wire logic                         cmd_noptr_in,
  input  wire logic [rtcis_pkg::PTR_W-1:0]  cmd_ptr_in,
  input  wire logic [7:0]                   cmd_len_in,
  // write data stream
  input  wire logic                         wdata_valid_in,
  output logic                              wdata_ready_out,
  input  wire logic [rtcis_pkg::BYTE_W-1:0] wdata_in,
  // read data and status
  output logic                              rdata_valid_out,
  output logic [rtcis_pkg::BYTE_W-1:0]      rdata_out,
  output logic                              done_out,
  output logic                              nack_out
);
  typedef enum logic [3:0] {
    H_IDLE, H_START, H_ADDRW, H_PTR, H_WDATA, H_RSTART, H_ADDRR, H_RDATA, H_STOP
  } rtcis_hst_t;
  typedef struct packed {
    logic                         sda_s1;
    logic                         sda_s2;
    rtcis_hst_t                   st;
    logic [7:0]                   cnt;
    logic [1:0]                   qtr;
    logic [3:0]                   bitn;
    logic [8:0]                   tx;
    logic [rtcis_pkg::BYTE_W-1:0] rx;
    logic                         ackv;
    logic [7:0]                   len;
    logic                         rd;
    logic                         loaded;
    logic [rtcis_pkg::PTR_W-1:0]  ptr;
    logic                         nack;
    logic                         scl_oe_n;
    logic                         sda_oe_n;
    logic                         rvalid;
    logic [rtcis_pkg::BYTE_W-1:0] rdata;
    logic                         done;
  } rtcis_host_st_t;
  rtcis_host_st_t               q;
  rtcis_host_st_t               d;
  logic                         f_valid;
  logic                         f_pop;
  logic [rtcis_pkg::BYTE_W-1:0] f_data;
  logic                         qend;
  logic                         hold;
  logic                         is_byte;
  logic [1:0]                   lvl;

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  rtcis_fifo #(.W(rtcis_pkg::BYTE_W), .DEPTH(rtcis_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wdata_valid_in),
    .in_ready_out  (wdata_ready_out),
    .in_data_in    (wdata_in),
    .out_valid_out (f_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_data)
  );

  // open-drain levels {scl, sda} for a state and phase
  function automatic logic [1:0] line_lvl(
    input rtcis_hst_t st,
    input logic [1:0] qtr,
    input logic       txb
  );
    logic clk_hi;
    clk_hi = (qtr == rtcis_pkg::Q1) || (qtr == rtcis_pkg::Q2);
    unique case (st)
      H_IDLE:            line_lvl = 2'h3;
      // fresh start keeps scl high from idle, so no short low pulse precedes it
      H_START:           line_lvl = {qtr != rtcis_pkg::Q3, qtr < rtcis_pkg::Q2};
      H_RSTART:          line_lvl = {clk_hi, qtr < rtcis_pkg::Q2};
      H_STOP:            line_lvl = {qtr != rtcis_pkg::Q0, qtr >= rtcis_pkg::Q2};
      default:           line_lvl = {clk_hi, txb};
    endcase
  endfunction : line_lvl

  assign qend    = (q.cnt == 8'(QTR - 1));
  assign is_byte = (q.st != H_IDLE) && (q.st != H_START) && (q.st != H_RSTART) && (q.st != H_STOP);
  assign hold    = (q.st == H_WDATA) && !q.loaded && q.bitn == '0 && q.qtr == rtcis_pkg::Q0
                   && q.cnt == '0;
  assign f_pop   = hold & f_valid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.rvalid = 1'b0;
    d.done   = 1'b0;
    if (q.st == H_IDLE)
    begin
      if (cmd_valid_in)
      begin
        d.st   = H_START;
        d.rd   = cmd_read_in;
        d.ptr  = cmd_ptr_in;
        d.len  = cmd_len_in;
        d.nack = 1'b0;
        d.cnt  = '0;
        d.qtr  = rtcis_pkg::Q0;
        d.bitn = '0;
        d.tx   = {rtcis_pkg::OWN_ADDR, (cmd_read_in && cmd_noptr_in) ? rtcis_pkg::DIR_RD
                  : rtcis_pkg::DIR_WR, rtcis_pkg::NACK_LVL};
        d.loaded = cmd_read_in && cmd_noptr_in;
      end
    end
    else if (hold)
    begin
      // stall with scl low until a byte is buffered
      if (f_valid)
      begin
        d.tx     = {f_data, rtcis_pkg::NACK_LVL};
        d.loaded = 1'b1;
      end
    end
    else
    begin
      d.cnt = qend ? '0 : 8'(q.cnt + 8'h01);
      if (qend)
      begin
        d.qtr = 2'(q.qtr + 2'h1);
        if (is_byte && q.qtr == rtcis_pkg::Q2)
        begin
          if (q.bitn == rtcis_pkg::ACK_SLOT)
          begin
            d.ackv = q.sda_s2;
          end
          else
          begin
            d.rx = {q.rx[rtcis_pkg::BYTE_W-2:0], q.sda_s2};
          end
        end
        if (q.qtr == rtcis_pkg::Q3)
        begin
          if (is_byte && q.bitn != rtcis_pkg::ACK_SLOT)
          begin
            d.bitn = 4'(q.bitn + rtcis_pkg::FIRST_BIT);
            d.tx   = {q.tx[7:0], 1'b0};
          end
          else
          begin
            d.bitn   = '0;
            d.loaded = 1'b0;
            unique case (q.st)
              H_START:
              begin
                d.st = q.loaded ? H_ADDRR : H_ADDRW;
              end
              H_ADDRW:
              begin
                d.st = H_PTR;
                d.tx = {4'h0, q.ptr, rtcis_pkg::NACK_LVL};
              end
              H_PTR:
              begin
                d.st = q.rd ? H_RSTART : ((q.len == '0) ? H_STOP : H_WDATA);
              end
              H_WDATA:
              begin
                d.len = 8'(q.len - 8'h01);
                d.st  = (q.len <= 8'h01) ? H_STOP : H_WDATA;
              end
              H_RSTART:
              begin
                d.st = H_ADDRR;
                d.tx = {rtcis_pkg::OWN_ADDR, rtcis_pkg::DIR_RD, rtcis_pkg::NACK_LVL};
              end
              H_ADDRR:
              begin
                d.st = H_RDATA;
                d.tx = {rtcis_pkg::ALL_ONES, (q.len <= 8'h01) ? rtcis_pkg::NACK_LVL
                        : rtcis_pkg::ACK_LVL};
              end
              H_RDATA:
              begin
                d.rvalid = 1'b1;
                d.rdata  = q.rx;
                d.len    = 8'(q.len - 8'h01);
                d.st     = (q.len <= 8'h01) ? H_STOP : H_RDATA;
                d.tx     = {rtcis_pkg::ALL_ONES, (q.len <= 8'h02) ? rtcis_pkg::NACK_LVL
                            : rtcis_pkg::ACK_LVL};
              end
              default:
              begin
                d.st   = H_IDLE;
                d.done = 1'b1;
              end
            endcase
            if (is_byte && q.st != H_RDATA && q.ackv == rtcis_pkg::NACK_LVL)
            begin
              d.nack = 1'b1;
              d.st   = H_STOP;
            end
          end
        end
      end
    end
    lvl        = line_lvl(d.st, d.qtr, d.tx[8]);
    d.scl_oe_n = lvl[1];
    d.sda_oe_n = lvl[0];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      q          <= '0;
      q.sda_s1   <= 1'b1;
      q.sda_s2   <= 1'b1;
      q.ackv     <= 1'b1;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.scl_m_out   = 1'b0;
  assign bus.sda_m_out   = 1'b0;
  assign bus.scl_m_oe_n  = q.scl_oe_n;
  assign bus.sda_m_oe_n  = q.sda_oe_n;
  assign cmd_ready_out   = (q.st == H_IDLE);
  assign rdata_valid_out = q.rvalid;
  assign rdata_out       = q.rdata;
  assign done_out        = q.done;
  assign nack_out        = q.nack;
endmodule : rtcis_host
`default_nettype wire

/* File: hw/rtcis_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rtcis_if;
  // master open-drain drivers
  logic scl_m_out;
  logic scl_m_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  // slave open-drain driver
  logic sda_s_out;
  logic sda_s_oe_n;
  // resolved wire levels, pulled up when released
  logic scl;
  logic sda;
  assign scl = scl_m_oe_n | scl_m_out;
  assign sda = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);
  modport master (output scl_m_out, scl_m_oe_n, sda_m_out, sda_m_oe_n, input scl, sda);
  modport slave  (output sda_s_out, sda_s_oe_n, input scl, sda);
endinterface : rtcis_if
`default_nettype wire

/* File: hw/rtcis_pkg.sv */
`default_nettype none
package rtcis_pkg;
  // ----------------------------------------------------------------
  // bus address and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] OWN_ADDR  = 7'h51;
  localparam logic       DIR_RD    = 1'h1;
  localparam logic       DIR_WR    = 1'h0;
  localparam logic       ACK_LVL   = 1'h0;
  localparam logic       NACK_LVL  = 1'h1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [3:0] FIRST_BIT = 4'h1;
  localparam logic [3:0] PTR_ONE   = 4'h1;
  localparam logic [7:0] ALL_ONES  = 8'hff;
  localparam int         PTR_W     = 4;
  localparam int         BYTE_W    = 8;
  // ----------------------------------------------------------------
  // master bit phases
  // ----------------------------------------------------------------
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;
  localparam int         QTR_CYCLES = 4;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TMO_TIME_NS   = 950_000_000;
  localparam int TMO_CYCLES    = (TMO_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH    = 32;
endpackage : rtcis_pkg
`default_nettype wire

/* File: testbench/rtcis_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcis_chk_sva #(
  parameter int TMO_CYC = rtcis_pkg::TMO_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // wire levels and device status
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe_n,
  input wire logic busy_out,
  input wire logic wr_en_out
);
  int busy_q;
  always_ff @(posedge core_clk_in) busy_q <= (!rst_n_in || !busy_out) ? 0 : busy_q + 1;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence low_ph;
    !scl [*8];
  endsequence
  sequence high_ph;
    scl [*8];
  endsequence
  oe_on_low_a: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("slave data changed while clock high");
  scl_low_a: assert property ($fell(scl) |-> low_ph)
    else $error("clock low phase too short");
  scl_high_a: assert property ($rose(scl) |-> high_ph)
    else $error("clock high phase too short");
  busy_start_a: assert property ($rose(busy_out) |-> !sda)
    else $error("busy rose without start");
  busy_stop_a: assert property ($fell(busy_out) && scl |-> sda)
    else $error("busy fell without stop");
  busy_bound_a: assert property (busy_out |-> busy_q <= TMO_CYC)
    else $error("transaction outlived timeout");
  idle_release_a: assert property ($fell(busy_out) |=> sda_s_oe_n [*8])
    else $error("slave drove data while idle");
  wr_busy_a: assert property (wr_en_out |-> busy_out && !scl)
    else $error("write strobe outside transfer");
  wr_pulse_a: assert property (wr_en_out |=> !wr_en_out)
    else $error("write strobe longer than one cycle");
endmodule : rtcis_chk_sva
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TMO = 2000;
  logic       core_clk_in, rst_n_in, cv, cr, crd, cnp, wv, wd_rdy, rv, done, nack;
  logic       wr_en, busy;
  logic [3:0] cp, rd_idx, wr_idx;
  logic [7:0] cl, wd, rdat, reg_rd, wr_data;
  logic [7:0] mem [16];
  int         m_mem [16];
  int         m_ptr, error_cnt, comparisons;
  int         wq [$];
  rtcis_if bus_if ();
  rtcis_dev #(.TMO_CYC(TMO)) rtcis_dev_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .bus(bus_if), .rd_idx_out(rd_idx), .rd_data_in(reg_rd), .wr_en_out(wr_en),
    .wr_idx_out(wr_idx), .wr_data_out(wr_data), .busy_out(busy));
  rtcis_host rtcis_host_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
    .cmd_valid_in(cv), .cmd_ready_out(cr), .cmd_read_in(crd), .cmd_noptr_in(cnp),
    .cmd_ptr_in(cp), .cmd_len_in(cl), .wdata_valid_in(wv), .wdata_ready_out(wd_rdy),
    .wdata_in(wd), .rdata_valid_out(rv), .rdata_out(rdat), .done_out(done), .nack_out(nack));
  rtcis_chk_sva #(.TMO_CYC(TMO)) rtcis_chk_sva_inst (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_s_oe_n(bus_if.sda_s_oe_n), .busy_out(busy), .wr_en_out(wr_en));
  // register file behind the device
  always @(posedge core_clk_in) if (wr_en) mem[wr_idx] <= wr_data;
  assign reg_rd = mem[rd_idx];
  initial
  begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic bail();
    error_cnt++;
    finish_test();
  endtask : bail
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic push(input logic [7:0] d);
    int k;
    for (k = 0; wd_rdy !== 1'b1; k++)
    begin
      if (k == 100) bail();
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    wv <= 1'b1;
    wd <= d;
    wq.push_back(int'(d));
    @(posedge core_clk_in);
    wv <= 1'b0;
  endtask : push
  // model: store the first n queued bytes, drop the rest
  task automatic apply(input int n);
    for (int i = 0; i < n; i++)
    begin
      m_mem[m_ptr] = wq.pop_front();
      m_ptr = (m_ptr + 1) % 16;
    end
    wq.delete();
  endtask : apply
  task automatic xfer(input logic rd, input logic np, input logic [3:0] p, input int n);
    int k;
    for (k = 0; cr !== 1'b1; k++)
    begin
      if (k == 100) bail();
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    cv <= 1'b1;
    crd <= rd;
    cnp <= np;
    cp <= p;
    cl <= n[7:0];
    @(posedge core_clk_in);
    cv <= 1'b0;
    if (!np) m_ptr = int'(p);
    for (k = 0; done !== 1'b1; k++)
    begin
      if (k == 20000) bail();
      @(negedge core_clk_in);
      if (rv === 1'b1)
      begin
        chk(rdat, m_mem[m_ptr][7:0]);
        m_ptr = (m_ptr + 1) % 16;
      end
    end
  endtask : xfer
  task automatic mem_cmp();
    for (int i = 0; i < 16; i++) chk(mem[i], m_mem[i][7:0]);
  endtask : mem_cmp
  initial
  begin
    int i;
    error_cnt = 0;
    comparisons = 0;
    m_ptr = 0;
    rst_n_in = 1'b0;
    cv = 1'b0;
    crd = 1'b0;
    cnp = 1'b0;
    cp = 4'h0;
    cl = 8'h00;
    wv = 1'b0;
    wd = 8'h00;
    void'($urandom(32'h818f_854d));
    for (i = 0; i < 16; i++)
    begin
      mem[i] = 8'($urandom);
      m_mem[i] = int'(mem[i]);
    end
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // write across the top register
    for (i = 0; i < 3; i++) push(8'($urandom));
    xfer(1'b0, 1'b0, 4'he, 3);
    apply(3);
    mem_cmp();
    chk({7'h00, nack}, 8'h00);
    $display("test write_wrap done");
    // pointed read, then reads that continue from the pointer
    xfer(1'b1, 1'b0, 4'he, 3);
    xfer(1'b1, 1'b1, 4'h0, 2);
    xfer(1'b0, 1'b0, 4'h5, 0);
    xfer(1'b1, 1'b1, 4'h0, 1);
    $display("test reads done");
    // host stalls mid-write past the bus timeout
    push(8'($urandom));
    fork
      xfer(1'b0, 1'b0, 4'h9, 2);
      begin
        repeat (TMO + 200) @(posedge core_clk_in);
        push(8'($urandom));
      end
    join
    apply(1);
    chk({7'h00, nack}, 8'h01);
    mem_cmp();
    xfer(1'b1, 1'b1, 4'h0, 2);
    $display("test timeout done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
